// ===== hdl/ddrimr_core.sv
// command decoder, mode registers, dll lock and init tracking
module ddrimr_core (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic cke_in,
   input wire logic cs_n_in,
   input wire logic ras_n_in,
   input wire logic cas_n_in,
   input wire logic we_n_in,
   input wire logic [ddrimr_pkg::ADDR_W-1:0] addr_in,
   input wire logic [ddrimr_pkg::BA_W-1:0] ba_in,
   input wire logic err_clr_in,
   output logic [2:0] burst_len_out,
   output logic [3:0] burst_beats_out,
   output logic burst_interleave_out,
   output logic [2:0] read_lat_out,
   output logic test_mode_out,
   output logic dll_reset_out,
   output logic dll_en_out,
   output logic [1:0] drive_str_out,
   output logic dll_locked_out,
   output logic mode_busy_out,
   output logic init_done_out,
   output logic cmd_error_out
);
   import ddrimr_pkg::*;

   // ----------------------------------------
   // pin synchronisation
   // ----------------------------------------
   localparam int PIN_W = 5 + ADDR_W + BA_W;
   logic [PIN_W-1:0] pins_s;           // synchronised pin group
   logic cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s;
   logic [ADDR_W-1:0] addr_s;
   logic [BA_W-1:0] ba_s;

   // whole group shares one delay, so address stays paired with its command
   ddrimr_sync2 #(.W(PIN_W)) u_pin_sync (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .d_in({cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in, addr_in, ba_in}),
      .q_out(pins_s)
   );
   assign {cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, addr_s, ba_s} = pins_s;

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   logic cmd_ok;     // decoder enabled this edge
   logic mode_wr;    // mode or extended write
   logic mrs, emrs;  // split by bank bit 0
   logic pall;       // precharge all banks
   logic aref;       // auto refresh
   logic any_cmd;    // any non-nop command

   // chip select high hides commands; clock enable must already be high
   always_comb begin
      cmd_ok = cke_s && !cs_n_s;                                  // RQ22 RQ23
      mode_wr = cmd_ok && !ras_n_s && !cas_n_s && !we_n_s;        // RQ11
      emrs = mode_wr && ba_s[BA_EMR_BIT];                         // RQ17
      mrs = mode_wr && !ba_s[BA_EMR_BIT];
      pall = cmd_ok && !ras_n_s && cas_n_s && !we_n_s && addr_s[AP_BIT];
      aref = cmd_ok && !ras_n_s && !cas_n_s && we_n_s;
      any_cmd = cmd_ok && !(ras_n_s && cas_n_s && we_n_s);
   end

   // ----------------------------------------
   // mode and extended mode registers
   // ----------------------------------------
   logic [ADDR_W-1:0] mr_reg, mr_next;    // mode register image
   logic [ADDR_W-1:0] emr_reg, emr_next;  // extended register image
   logic [BA_W-1:0] mr_ba_reg, mr_ba_next;
   logic [3:0] beats_reg, beats_next;
   logic dll_en_reg, dll_en_next;  // registered dll enable, keeps the output a flop

   // address and bank captured on the very edge the command is decoded
   always_comb begin
      mr_next = mr_reg;
      emr_next = emr_reg;
      mr_ba_next = mr_ba_reg;
      beats_next = beats_reg;
      if (mrs) begin
         mr_next = addr_s;                                         // RQ12
         mr_ba_next = ba_s;                                        // RQ12
         unique case (addr_s[MR_BL_MSB:MR_BL_LSB])                 // RQ24
            BL_2: beats_next = BEATS_2;
            BL_4: beats_next = BEATS_4;
            BL_8: beats_next = BEATS_8;
            default: beats_next = BEATS_NONE;  // reserved or full page
         endcase
      end
      if (emrs) begin
         emr_next = addr_s;                                        // RQ12
      end
      dll_en_next = !emr_next[EMR_DLL_BIT];                        // RQ19
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mr_reg <= MR_RST;
         emr_reg <= EMR_RST;
         mr_ba_reg <= '0;
         beats_reg <= BEATS_NONE;
         dll_en_reg <= 1'b0;
      end else begin
         mr_reg <= mr_next;
         emr_reg <= emr_next;
         mr_ba_reg <= mr_ba_next;
         beats_reg <= beats_next;
         dll_en_reg <= dll_en_next;
      end
   end

   // ----------------------------------------
   // dll lock counter and mode write busy window
   // ----------------------------------------
   logic [7:0] lock_cnt_reg, lock_cnt_next;  // cycles since dll reset
   logic locked_reg, locked_next;
   logic [1:0] busy_cnt_reg, busy_cnt_next;  // remaining busy cycles
   logic busy_reg, busy_next;                // registered busy flag
   logic err_reg, err_next;

   // a dll reset restarts the wait; a disabled dll never reports lock
   always_comb begin
      lock_cnt_next = lock_cnt_reg;
      locked_next = locked_reg;
      if ((mrs && addr_s[MR_DLLRST_BIT]) || (emrs && addr_s[EMR_DLL_BIT])) begin
         lock_cnt_next = '0;                                       // RQ5
         locked_next = 1'b0;
      end else if (!emr_reg[EMR_DLL_BIT] && !locked_reg) begin
         lock_cnt_next = lock_cnt_reg + 8'h01;
         locked_next = (lock_cnt_reg == 8'(DLL_LOCK_CYC - 1));     // RQ5
      end
      busy_cnt_next = (busy_cnt_reg != 2'h0) ? busy_cnt_reg - 2'h1 : 2'h0;
      if (mode_wr) begin
         busy_cnt_next = 2'(MODE_WAIT_CYC);
      end
      busy_next = (busy_cnt_next != 2'h0);
      // a command inside the busy window is flagged; the set beats a clear
      err_next = err_reg && !err_clr_in;
      if (any_cmd && busy_cnt_reg != 2'h0) begin
         err_next = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lock_cnt_reg <= '0;
         locked_reg <= 1'b0;
         busy_cnt_reg <= '0;
         busy_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         lock_cnt_reg <= lock_cnt_next;
         locked_reg <= locked_next;
         busy_cnt_reg <= busy_cnt_next;
         busy_reg <= busy_next;
         err_reg <= err_next;
      end
   end

   // ----------------------------------------
   // initialization progress tracker
   // ----------------------------------------
   ddrimr_init_t st_reg, st_next;
   logic rst_seen_reg, rst_seen_next;    // dll-reset write seen
   logic pall2_reg, pall2_next;          // second precharge seen
   logic [1:0] ref_cnt_reg, ref_cnt_next;

   // second precharge and dll reset may come in either order
   always_comb begin
      st_next = st_reg;
      rst_seen_next = rst_seen_reg;
      pall2_next = pall2_reg;
      ref_cnt_next = ref_cnt_reg;
      unique case (st_reg)
         INIT_PWR: if (cke_s) st_next = INIT_PALL1;
         INIT_PALL1: if (pall) st_next = INIT_EMRS;
         INIT_EMRS: if (emrs) st_next = INIT_MID;
         INIT_MID: begin
            // mode register only counts once the extended one is set
            if (mrs && addr_s[MR_DLLRST_BIT]) rst_seen_next = 1'b1;  // RQ10
            if (pall) pall2_next = 1'b1;
            if ((rst_seen_reg || (mrs && addr_s[MR_DLLRST_BIT])) &&
                (pall2_reg || pall)) begin
               st_next = INIT_REF;
               ref_cnt_next = '0;
            end
         end
         INIT_REF: begin
            if (aref && ref_cnt_reg != 2'(REF_MIN)) begin
               ref_cnt_next = ref_cnt_reg + 2'h1;
            end
            if (mrs && !addr_s[MR_DLLRST_BIT] && ref_cnt_reg == 2'(REF_MIN)) begin
               st_next = INIT_DONE;                                  // RQ10
            end
         end
         INIT_DONE: st_next = INIT_DONE;
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_reg <= INIT_PWR;
         rst_seen_reg <= 1'b0;
         pall2_reg <= 1'b0;
         ref_cnt_reg <= '0;
      end else begin
         st_reg <= st_next;
         rst_seen_reg <= rst_seen_next;
         pall2_reg <= pall2_next;
         ref_cnt_reg <= ref_cnt_next;
      end
   end

   // ----------------------------------------
   // outputs, each straight from a flip-flop
   // ----------------------------------------
   logic done_reg;  // registered init state, keeps the output a flop
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= (st_next == INIT_DONE);
      end
   end

   // field slices of the held images
   assign burst_len_out = mr_reg[MR_BL_MSB:MR_BL_LSB];           // RQ15
   assign burst_beats_out = beats_reg;
   assign burst_interleave_out = mr_reg[MR_BT_BIT];              // RQ15
   assign read_lat_out = mr_reg[MR_CL_MSB:MR_CL_LSB];            // RQ15
   assign test_mode_out = mr_reg[MR_TM_BIT];
   assign dll_reset_out = mr_reg[MR_DLLRST_BIT];
   assign dll_en_out = dll_en_reg;                               // RQ19
   assign drive_str_out = {emr_reg[EMR_DS1_BIT], emr_reg[EMR_DS0_BIT]};  // RQ19
   assign dll_locked_out = locked_reg;
   assign mode_busy_out = busy_reg;
   assign init_done_out = done_reg;
   assign cmd_error_out = err_reg;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   logic [8:0] since_rst_reg;  // helper: cycles since last dll reset write
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         since_rst_reg <= '0;
      end else if (mrs && addr_s[MR_DLLRST_BIT]) begin
         since_rst_reg <= 9'h001;
      end else if (since_rst_reg != 9'h1ff) begin
         since_rst_reg <= since_rst_reg + 9'h001;
      end
   end

   sequence s_mode_cmd;
      !cs_n_s && cke_s && !ras_n_s && !cas_n_s && !we_n_s;
   endsequence
   sequence s_emr_ok;
      (st_reg == INIT_MID) ##1 (st_reg == INIT_REF);
   endsequence

   a_lock_time: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ5
      $rose(locked_reg) |-> since_rst_reg == 9'(DLL_LOCK_CYC) + 9'h001)
      else $error("dll lock not 200 cycles after reset");
   a_mode_init_order: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ10
      $rose(done_reg) |-> $past(pall2_reg, 2) && $past(rst_seen_reg, 2))
      else $error("init done without full sequence");
   a_mode_decode: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ11
      (s_mode_cmd ##0 !ba_s[BA_EMR_BIT]) |=> mr_reg == $past(addr_s))
      else $error("mode write not decoded");
   a_addr_capture: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ12
      mrs |=> mr_ba_reg == $past(ba_s) ##1 mode_busy_out [*1])
      else $error("bank bits not captured with command");
   a_field_place: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ15
      mrs |=> read_lat_out == $past(addr_s[MR_CL_MSB:MR_CL_LSB]) &&
              burst_len_out == $past(addr_s[MR_BL_MSB:MR_BL_LSB]))
      else $error("mode fields misplaced");
   a_ext_select: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ17
      emrs |=> $stable(mr_reg) && emr_reg == $past(addr_s))
      else $error("extended write hit mode register");
   a_drive_str: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ19
      emrs |=> drive_str_out == {$past(addr_s[EMR_DS1_BIT]), $past(addr_s[EMR_DS0_BIT])}
               && dll_en_out == !$past(addr_s[EMR_DLL_BIT]))
      else $error("extended fields misplaced");
   a_cs_ignore: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ22
      (cs_n_s || !cke_s) [*2] |=> $stable(mr_reg) && $stable(emr_reg))
      else $error("command taken with chip select high");
   a_beats_code: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ24
      (mrs && addr_s[MR_BL_MSB:MR_BL_LSB] == BL_4) |=> burst_beats_out == BEATS_4)
      else $error("burst length 4 misdecoded");
   a_ext_then_mode: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ10
      s_emr_ok |-> $past(rst_seen_reg) || $past(mrs))
      else $error("init advanced without dll reset write");
endmodule

// ===== hdl/ddrimr_pkg.sv
// constants for the ddr sdram init and mode register block
// What the block and its controller must do
// [RQ1] controller holds clock enable low at power-up
// [RQ2] controller waits 200 us stable clock first
// [RQ3] controller then drives nop, raises clock enable
// [RQ4] precharge all, then extended write enabling dll
// [RQ5] dll-reset mode write, 200 cycles to lock
// [RQ6] second precharge all before or after reset
// [RQ7] at least two refreshes after second precharge
// [RQ8] last step: mode write with bit 8 low
// [RQ9] frequency change needs dll reset, 200 cycles
// [RQ10] mode register written after extended register
// [RQ11] all strobes low with clock enable: mode write
// [RQ12] address and bank captured on command edge
// [RQ13] two cycles after mode write before next
// [RQ14] mode write only when banks idle, after tRP
// [RQ15] fields: length, order, latency, test, dll reset
// [RQ16] normal write keeps test, reset, bank low
// [RQ17] bank bit 0 high selects extended register
// [RQ18] extended write only when idle, clock enabled
// [RQ19] extended: bit 0 dll, bits 1,6 drive strength
// [RQ20] extended write drives unused address bits low
// [RQ21] two cycles after extended write before next
// [RQ22] chip select high ignores new commands
// [RQ23] inputs sampled on rising system clock edge
// [RQ24] length 001/010/011, sequential 0, latency 3 011
package ddrimr_pkg;
   // ----------------------------------------
   // pin widths
   // ----------------------------------------
   localparam int ADDR_W = 12;          // address pins
   localparam int BA_W = 2;             // bank address pins
   // ----------------------------------------
   // mode register field positions
   // ----------------------------------------
   localparam int MR_BL_LSB = 0;        // burst length low bit
   localparam int MR_BL_MSB = 2;        // burst length high bit
   localparam int MR_BT_BIT = 3;        // burst ordering
   localparam int MR_CL_LSB = 4;        // read latency low bit
   localparam int MR_CL_MSB = 6;        // read latency high bit
   localparam int MR_TM_BIT = 7;        // test mode
   localparam int MR_DLLRST_BIT = 8;    // dll reset
   // ----------------------------------------
   // extended mode register field positions
   // ----------------------------------------
   localparam int EMR_DLL_BIT = 0;      // high disables the dll
   localparam int EMR_DS0_BIT = 1;      // drive strength, low bit
   localparam int EMR_DS1_BIT = 6;      // drive strength, high bit
   localparam int BA_EMR_BIT = 0;       // selects extended register
   localparam int AP_BIT = 10;          // all-banks bit on precharge
   // ----------------------------------------
   // field encodings
   // ----------------------------------------
   localparam logic [2:0] BL_2 = 3'h1;
   localparam logic [2:0] BL_4 = 3'h2;
   localparam logic [2:0] BL_8 = 3'h3;
   localparam logic BT_SEQ = 1'h0;
   localparam logic [2:0] CL_3 = 3'h3;
   localparam logic [3:0] BEATS_2 = 4'h2;
   localparam logic [3:0] BEATS_4 = 4'h4;
   localparam logic [3:0] BEATS_8 = 4'h8;
   localparam logic [3:0] BEATS_NONE = 4'h0;
   // ----------------------------------------
   // reset values (content is undefined until written)
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] MR_RST = 12'h000;
   localparam logic [ADDR_W-1:0] EMR_RST = 12'h001;
   // ----------------------------------------
   // timing counts, in clock cycles
   // ----------------------------------------
   localparam int DLL_LOCK_CYC = 200;   // relock wait after dll reset
   localparam int MODE_WAIT_CYC = 2;    // mode write completion
   localparam int REF_MIN = 2;          // refreshes during init
   // ----------------------------------------
   // initialization progress
   // ----------------------------------------
   typedef enum logic [2:0] {
      INIT_PWR, INIT_PALL1, INIT_EMRS, INIT_MID, INIT_REF, INIT_DONE
   } ddrimr_init_t;
endpackage

// ===== hdl/ddrimr_sync2.sv
// two flip-flop synchroniser for a group of pin inputs
module ddrimr_sync2 #(
   parameter int W = 1
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] s1_reg;  // first stage, read only by the second
   logic [W-1:0] s1_next;
   logic [W-1:0] s2_reg;  // second stage, safe to use
   logic [W-1:0] s2_next;

   // next values: a plain shift
   always_comb begin
      s1_next = d_in;
      s2_next = s1_reg;
   end

   // registers, cleared to zero under reset
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_reg <= '0;
         s2_reg <= '0;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
      end
   end

   assign q_out = s2_reg;
endmodule

// ===== tb/ddrimr_ctrl_model.sv
// partner model: memory controller driving the command and address pins
module ddrimr_ctrl_model #(
   parameter int STABLE_CYC = 20000, // 200 us of stable clock at 100 MHz
   parameter int RP_CYC = 5          // row precharge wait, plain default
) (
   input wire logic clk_sys_in,
   output logic cke_out,
   output logic cs_n_out,
   output logic ras_n_out,
   output logic cas_n_out,
   output logic we_n_out,
   output logic [ddrimr_pkg::ADDR_W-1:0] addr_out,
   output logic [ddrimr_pkg::BA_W-1:0] ba_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import ddrimr_pkg::*;
   // ----------------------------------------
   // command codes as {cs_n, ras_n, cas_n, we_n}
   // ----------------------------------------
   localparam logic [3:0] CMD_MODE = 4'h0; // mode or extended write
   localparam logic [3:0] CMD_PRE = 4'h2;  // precharge
   localparam logic [3:0] CMD_REF = 4'h1;  // auto refresh
   localparam logic [3:0] CMD_NOP = 4'h7;  // no operation
   // power-up state: clock enable low, pins parked on nop
   initial begin
      cke_out = 1'b0;
      {cs_n_out, ras_n_out, cas_n_out, we_n_out} = CMD_NOP;
      addr_out = 12'h000;
      ba_out = 2'h0;
   end
   // one command edge, then nop cycles; address is not held, so it wanders
   task automatic cmd(input logic [3:0] code, input logic [ADDR_W-1:0] a,
                      input logic [BA_W-1:0] b, input int gap);
      @(posedge clk_sys_in);
      {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= code;
      addr_out <= a;
      ba_out <= b;
      repeat (gap) begin
         @(posedge clk_sys_in);
         {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= CMD_NOP;
         addr_out <= ~addr_out; // released pins must not look held
         ba_out <= ~ba_out;
      end
   endtask
   // clock enable level, changed on an edge
   task automatic set_cke(input logic v);
      @(posedge clk_sys_in);
      cke_out <= v;
   endtask
   // cke low through the stable-clock wait, then nop with cke high
   task automatic power_up();
      set_cke(1'b0);
      repeat (STABLE_CYC) @(posedge clk_sys_in);
      set_cke(1'b1);
      repeat (2) @(posedge clk_sys_in);
   endtask
   // precharge all banks, then wait out the row precharge time
   task automatic pre_all();
      cmd(CMD_PRE, 12'h400, 2'h0, RP_CYC);
   endtask
   // auto refresh with a short settle gap
   task automatic refresh();
      cmd(CMD_REF, 12'h000, 2'h0, 4);
   endtask
   // mode or extended write; three quiet cycles after it
   task automatic mode_cmd(input logic [ADDR_W-1:0] a, input logic [BA_W-1:0] b);
      cmd(CMD_MODE, a, b, 3);
   endtask
endmodule

// ===== tb/tb_ddrimr_core.sv
// self-checking bench for the command decoder and mode registers
module tb_ddrimr_core;
   timeunit 1ns;
   timeprecision 1ps;
   import ddrimr_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk_sys_in, rst_n_in, cke, cs_n, ras_n, cas_n, we_n, err_clr;
   logic [ADDR_W-1:0] addr;
   logic [BA_W-1:0] ba;
   logic [2:0] burst_len_out, read_lat_out;
   logic [3:0] burst_beats_out;
   logic [1:0] drive_str_out;
   logic burst_interleave_out, test_mode_out, dll_reset_out, dll_en_out;
   logic dll_locked_out, mode_busy_out, init_done_out, cmd_error_out;
   logic busy_prev;                       // edge detect for results
   logic [ADDR_W-1:0] exp_mr, exp_emr;    // expected register images
   logic [2*ADDR_W-1:0] q[$];             // notes: {mode, extended}
   logic [2*ADDR_W-1:0] e;
   int failures, checks, ord, i;
   // ----------------------------------------
   // instances
   // ----------------------------------------
   ddrimr_ctrl_model ctrl (.clk_sys_in(clk_sys_in), .cke_out(cke), .cs_n_out(cs_n),
      .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .addr_out(addr), .ba_out(ba));
   ddrimr_core dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cke_in(cke),
      .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .addr_in(addr),
      .ba_in(ba), .err_clr_in(err_clr), .burst_len_out(burst_len_out),
      .burst_beats_out(burst_beats_out), .burst_interleave_out(burst_interleave_out),
      .read_lat_out(read_lat_out), .test_mode_out(test_mode_out),
      .dll_reset_out(dll_reset_out), .dll_en_out(dll_en_out), .drive_str_out(drive_str_out),
      .dll_locked_out(dll_locked_out), .mode_busy_out(mode_busy_out),
      .init_done_out(init_done_out), .cmd_error_out(cmd_error_out));
   // 100 mhz clock
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   // ----------------------------------------
   // checking helpers
   // ----------------------------------------
   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         failures++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   // all field outputs against two register images
   task automatic check_fields(input logic [ADDR_W-1:0] mr, input logic [ADDR_W-1:0] emr);
      logic [3:0] beats;
      beats = (mr[2:0] == BL_2) ? BEATS_2 : (mr[2:0] == BL_4) ? BEATS_4 :
              (mr[2:0] == BL_8) ? BEATS_8 : BEATS_NONE;
      chk(burst_len_out === mr[MR_BL_MSB:MR_BL_LSB], "burst length");
      chk(burst_beats_out === beats, "burst beats");
      chk(burst_interleave_out === mr[MR_BT_BIT], "burst order");
      chk(read_lat_out === mr[MR_CL_MSB:MR_CL_LSB], "read latency");
      chk(test_mode_out === mr[MR_TM_BIT], "test mode");
      chk(dll_reset_out === mr[MR_DLLRST_BIT], "dll reset bit");
      chk(dll_en_out === ~emr[EMR_DLL_BIT], "dll enable");
      chk(drive_str_out === {emr[EMR_DS1_BIT], emr[EMR_DS0_BIT]}, "drive strength");
   endtask
   // each rise of busy is one completed write: compare with oldest note
   always @(negedge clk_sys_in) begin
      if (rst_n_in === 1'b1 && busy_prev === 1'b0 && mode_busy_out === 1'b1) begin
         if (q.size() == 0) begin
            chk(1'b0, "write seen with nothing expected");
         end else begin
            e = q.pop_front();
            check_fields(e[2*ADDR_W-1:ADDR_W], e[ADDR_W-1:0]);
         end
      end
      busy_prev = mode_busy_out;
   end
   // ----------------------------------------
   // stimulus helpers
   // ----------------------------------------
   task automatic mode_wr(input logic [ADDR_W-1:0] a);
      exp_mr = a;
      q.push_back({exp_mr, exp_emr});
      ctrl.mode_cmd(a, 2'h0);
   endtask
   task automatic ext_wr(input logic [ADDR_W-1:0] a);
      exp_emr = a;
      q.push_back({exp_mr, exp_emr});
      ctrl.mode_cmd(a, 2'h1);
   endtask
   // random legal mode value; test mode kept low
   function automatic logic [ADDR_W-1:0] rnd_mr(input logic dll_rst);
      logic [ADDR_W-1:0] a;
      a = 12'h000;
      a[2:0] = 3'($urandom_range(3, 1));
      a[3] = 1'($urandom);
      a[6:4] = 3'($urandom);
      a[8] = dll_rst;
      return a;
   endfunction
   // random drive strength, dll bit given
   function automatic logic [ADDR_W-1:0] rnd_emr(input logic dll_off);
      logic [ADDR_W-1:0] a;
      a = 12'h000;
      a[0] = dll_off;
      a[1] = 1'($urandom);
      a[6] = 1'($urandom);
      return a;
   endfunction
   // reset for 12 edges; register images go back to their reset values
   task automatic reset_dut();
      ctrl.set_cke(1'b0);
      rst_n_in <= 1'b0;
      repeat (12) @(posedge clk_sys_in);
      q.delete();
      exp_mr = MR_RST;
      exp_emr = EMR_RST;
      @(negedge clk_sys_in);
      check_fields(exp_mr, exp_emr);
      chk({dll_locked_out, mode_busy_out, init_done_out, cmd_error_out} === 4'h0, "reset");
      @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
   endtask
   // verdict
   task automatic results();
      if (failures == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // watchdog: two power-ups of 20000 cycles plus 20000 more
   initial begin
      #600000;
      failures++;
      results();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst_n_in = 1'b0;
      err_clr = 1'b0;
      busy_prev = 1'b0;
      failures = 0;
      checks = 0;
      void'($urandom(32'he879));
      // two init runs; the second swaps dll reset and second precharge
      for (ord = 0; ord < 2; ord++) begin
         reset_dut();
         ctrl.power_up();
         ctrl.pre_all();
         ext_wr(rnd_emr(1'b0));
         if (ord == 0) begin
            mode_wr(rnd_mr(1'b1));
            ctrl.pre_all();
         end else begin
            ctrl.pre_all();
            mode_wr(rnd_mr(1'b1));
         end
         @(negedge clk_sys_in);
         chk(dll_locked_out === 1'b0, "lock before wait");
         repeat (150) @(negedge clk_sys_in);
         chk(dll_locked_out === 1'b0, "lock too early");
         for (i = 0; i < 80 && dll_locked_out !== 1'b1; i++) @(negedge clk_sys_in);
         chk(dll_locked_out === 1'b1, "no lock");
         repeat (2) ctrl.refresh();
         chk(init_done_out === 1'b0, "init done early");
         mode_wr(rnd_mr(1'b0));
         repeat (6) @(negedge clk_sys_in);
         chk(init_done_out === 1'b1, "init not done");
      end
      // every legal burst code and ordering, reserved code 111 included
      for (i = 0; i < 8; i++) begin
         mode_wr({5'h00, 3'($urandom), i[0],
                  (i[2:1] == 2'h0) ? 3'h7 : {1'b0, i[2:1]}});
      end
      // dll off drops lock, then back on
      ext_wr(rnd_emr(1'b1));
      repeat (4) @(negedge clk_sys_in);
      chk(dll_locked_out === 1'b0, "lock with dll off");
      ext_wr(rnd_emr(1'b0));
      // a fresh dll reset must relock, as after a clock change
      mode_wr(rnd_mr(1'b1));
      repeat (205) @(negedge clk_sys_in);
      chk(dll_locked_out === 1'b1, "no relock after dll reset");
      // deselected and clock-disabled writes are ignored
      ctrl.cmd(4'h8, 12'h0f3, 2'h0, 5);
      ctrl.set_cke(1'b0);
      ctrl.cmd(4'h0, 12'h0f3, 2'h0, 5);
      ctrl.set_cke(1'b1);
      repeat (4) @(negedge clk_sys_in);
      check_fields(exp_mr, exp_emr);
      // command straight after a write raises the error flag
      exp_mr = rnd_mr(1'b0);
      q.push_back({exp_mr, exp_emr});
      ctrl.cmd(4'h0, exp_mr, 2'h0, 0);
      ctrl.cmd(4'h2, 12'h400, 2'h0, 6);
      chk(cmd_error_out === 1'b1, "busy violation");
      @(posedge clk_sys_in);
      err_clr <= 1'b1;
      @(posedge clk_sys_in);
      err_clr <= 1'b0;
      @(negedge clk_sys_in);
      chk(cmd_error_out === 1'b0, "error clear");
      chk(q.size() == 0, "writes missing");
      results();
   end
endmodule
